// ===== design/srx_consts.svh
`ifndef SRX_CONSTS_SVH
`define SRX_CONSTS_SVH

// ==========================================
// register offsets (3-bit address)
`define SRX_OFF_STATUS   3'h0
`define SRX_OFF_CTRL_ONE 3'h1
`define SRX_OFF_CTRL_TWO 3'h2
`define SRX_OFF_DATA     3'h3
`define SRX_OFF_BAUD     3'h4

// ==========================================
// reset values
`define SRX_RST_STATUS   8'hc0
`define SRX_RST_CTRL_ONE 8'h00
`define SRX_RST_CTRL_TWO 8'h00
`define SRX_RST_BAUD     8'h00

// ==========================================
// status field positions
`define SRX_ST_TX_EMPTY_FLAG 7
`define SRX_ST_TC   6
`define SRX_ST_RX_DATA_READY_FLAG 5
`define SRX_ST_IDLE 4
`define SRX_ST_OVR  3
`define SRX_ST_NF   2
`define SRX_ST_FE   1
`define SRX_ST_PE   0

// ==========================================
// serial_ctrl_one field positions
`define SRX_C1_R8   7
`define SRX_C1_T8   6
`define SRX_C1_M    4
`define SRX_C1_WAKE 3
`define SRX_C1_PCE  2
`define SRX_C1_PS   1
`define SRX_C1_PIE  0

// ==========================================
// serial_ctrl_two field positions
`define SRX_C2_TIE  7
`define SRX_C2_TX_COMPLETE_IRQ_EN 6
`define SRX_C2_RIE  5
`define SRX_C2_IDLE_IRQ_EN 4
`define SRX_C2_TE   3
`define SRX_C2_RE   2
`define SRX_C2_MUTE 1

// ==========================================
// oversampling: samples numbered 1..16 from the start edge
`define SRX_SMP_LAST  5'h10
`define SRX_SMP_MAJ_A 5'h08
`define SRX_SMP_MAJ_B 5'h09
`define SRX_SMP_MAJ_C 5'h0a
`define SRX_SMP_E3    5'h03
`define SRX_SMP_E5    5'h05
`define SRX_SMP_E7    5'h07

`endif

// ===== design/srx_pkg.sv
package srx_pkg;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } srx_rx_state_t;

  typedef enum logic [0:0] {
    TX_IDLE,
    TX_SHIFT
  } srx_tx_state_t;

endpackage

// ===== design/srx_tx_if.sv
interface srx_tx_if;
  logic       run;
  logic       tick;
  logic       pend;
  logic [8:0] data;
  logic       m;
  logic       parity_ctrl_en;
  logic       ps;
  logic       te;
  logic       take;
  logic       done;
  logic       line;

  modport ctl (output run, tick, pend, data, m, parity_ctrl_en, ps, te, input take, done, line);
  modport eng (input run, tick, pend, data, m, parity_ctrl_en, ps, te, output take, done, line);
endinterface

// ===== design/srx_tx.sv
`include "srx_consts.svh"

module srx_tx (
  input  wire logic ref_clk_i,
  input  wire logic arst_n_i,
  srx_tx_if.eng     tx
);

  srx_pkg::srx_tx_state_t st_q;
  logic [10:0]            sh_q;
  logic [3:0]             nleft_q;
  logic [4:0]             smp_q;
  logic [8:0]             word;

  // ==========================================
  // parity replaces the top bit of the written word
  always_comb begin
    word = tx.data;
    if (tx.parity_ctrl_en) begin
      if (tx.m) begin
        word[8] = (^tx.data[7:0]) ^ tx.ps;
      end else begin
        word[7] = (^tx.data[6:0]) ^ tx.ps;
      end
    end
  end

  // ==========================================
  // frame shifter: start, data lsb first, stop
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q    <= srx_pkg::TX_IDLE;
      sh_q    <= 11'h7ff;
      nleft_q <= 4'h0;
      smp_q   <= 5'h00;
      tx.take <= 1'b0;
      tx.done <= 1'b0;
      tx.line <= 1'b1;
    end else if (tx.run) begin
      tx.take <= 1'b0;
      tx.done <= 1'b0;
      case (st_q)
        srx_pkg::TX_IDLE: begin
          tx.line <= 1'b1;
          if (tx.te && tx.pend && tx.tick) begin
            sh_q    <= tx.m ? {1'b1, word, 1'b0} : {2'b11, word[7:0], 1'b0};
            nleft_q <= tx.m ? 4'hb : 4'ha;
            smp_q   <= 5'h01;
            tx.take <= 1'b1;
            tx.line <= 1'b0;
            st_q    <= srx_pkg::TX_SHIFT;
          end
        end
        srx_pkg::TX_SHIFT: begin
          if (tx.tick) begin
            if (smp_q == `SRX_SMP_LAST) begin
              smp_q <= 5'h01;
              if (nleft_q == 4'h1) begin
                tx.done <= 1'b1;
                tx.line <= 1'b1;
                st_q    <= srx_pkg::TX_IDLE;
              end else begin
                nleft_q <= nleft_q - 4'h1;
                sh_q    <= {1'b1, sh_q[10:1]};
                tx.line <= sh_q[1];
              end
            end else begin
              smp_q <= smp_q + 5'h01;
            end
          end
        end
        default: st_q <= srx_pkg::TX_IDLE;
      endcase
    end
  end

endmodule

// ===== design/srx_top.sv
// Chosen here: strobed register access and the address map.
`include "srx_consts.svh"

module srx_top (
  input  wire logic       ref_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       halt_i,
  input  wire logic       cpu_int_mask_i,
  input  wire logic       rx_i,
  output logic [7:0]      rdata_o,
  output logic            irq_o,
  output logic            tx_o
);

  srx_tx_if txif ();

  logic       run;
  logic [1:0] rx_sync_q;
  logic       smp_in;
  logic [7:0] div_q;
  logic       tick_q;

  logic [7:0] ctrl_one_q;
  logic [7:0] ctrl_two_q;
  logic [7:0] baud_q;
  logic [8:0] tdr_q;
  logic       tdr_full_q;
  logic       seq_q;
  logic       data_rd_clr;
  logic       data_wr_clr;

  logic       tx_empty_flag_q;
  logic       tx_complete_flag_q;
  logic       rx_data_ready_flag_q;
  logic       idle_flag_q;
  logic       ovr_flag_q;
  logic       noise_flag_q;
  logic       frame_err_flag_q;
  logic       parity_error_flag_q;
  logic [8:0] rdr_q;

  srx_pkg::srx_rx_state_t rx_st_q;
  logic [4:0] smp_q;
  logic [3:0] bidx_q;
  logic [2:0] hist_q;
  logic [1:0] s89_q;
  logic [8:0] rsh_q;
  logic       noise_acc_q;
  logic       m_f_q;
  logic       pce_f_q;
  logic       ps_f_q;
  logic [7:0] idle_cnt_q;
  logic       idle_arm_q;
  logic       rx_mute;
  logic       maj;
  logic       unequal;
  logic       at_maj_c;
  logic       frame_end;
  logic       stop_bad;
  logic       msb;
  logic       par_err;
  logic       accept;
  logic       addr_wake;
  logic       idle_hit;
  logic [7:0] idle_len;
  logic       irq_d;

  assign run     = !halt_i;
  assign smp_in  = rx_sync_q[1];
  assign rx_mute = ctrl_two_q[`SRX_C2_MUTE];

  // ==========================================
  // rx pin synchroniser
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_sync_q <= 2'b11;
    end else begin
      rx_sync_q <= {rx_sync_q[0], rx_i};
    end
  end

  // ==========================================
  // 16x sampling tick from the baud divider
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q  <= 8'h00;
      tick_q <= 1'b0;
    end else if (run) begin
      if (div_q >= baud_q) begin
        div_q  <= 8'h00;
        tick_q <= 1'b1;
      end else begin
        div_q  <= div_q + 8'h01;
        tick_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // transmit engine hookup
  assign txif.run  = run;
  assign txif.tick = tick_q;
  assign txif.pend = tdr_full_q;
  assign txif.data = tdr_q;
  assign txif.m    = ctrl_one_q[`SRX_C1_M];
  assign txif.parity_ctrl_en  = ctrl_one_q[`SRX_C1_PCE];
  assign txif.ps   = ctrl_one_q[`SRX_C1_PS];
  assign txif.te   = ctrl_two_q[`SRX_C2_TE];
  assign tx_o      = txif.line;

  srx_tx u_tx (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .tx        (txif.eng)
  );

  // ==========================================
  // receive datapath decode
  assign at_maj_c  = tick_q && (smp_q == `SRX_SMP_MAJ_C);
  assign maj       = (s89_q[0] & s89_q[1]) | (s89_q[0] & smp_in) | (s89_q[1] & smp_in);
  assign unequal   = !((s89_q == 2'b00 && !smp_in) || (s89_q == 2'b11 && smp_in));
  assign frame_end = run && (rx_st_q == srx_pkg::RX_STOP) && at_maj_c;
  assign stop_bad  = !maj;
  // address mark looks at the data msb, never at the parity slot
  assign msb       = m_f_q ? (pce_f_q ? rsh_q[7] : rsh_q[8]) : (pce_f_q ? rsh_q[6] : rsh_q[7]);
  assign par_err   = pce_f_q && (((^(m_f_q ? rsh_q : {1'b0, rsh_q[7:0]}))) ^ ps_f_q);
  assign addr_wake = rx_mute && ctrl_one_q[`SRX_C1_WAKE] && msb;
  assign accept    = !rx_mute || addr_wake;
  assign idle_len  = ctrl_one_q[`SRX_C1_M] ? 8'hb0 : 8'ha0;
  assign idle_hit  = run && tick_q && (rx_st_q == srx_pkg::RX_IDLE) && smp_in &&
                     idle_arm_q && (idle_cnt_q == idle_len - 8'h01);

  // ==========================================
  // receive sequencer
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_st_q     <= srx_pkg::RX_IDLE;
      smp_q       <= 5'h00;
      bidx_q      <= 4'h0;
      hist_q      <= 3'b000;
      s89_q       <= 2'b00;
      rsh_q       <= 9'h000;
      noise_acc_q <= 1'b0;
      m_f_q       <= 1'b0;
      pce_f_q     <= 1'b0;
      ps_f_q      <= 1'b0;
    end else if (run && tick_q) begin
      if (smp_q == `SRX_SMP_MAJ_A || smp_q == `SRX_SMP_MAJ_B) begin
        s89_q <= {s89_q[0], smp_in};
      end
      case (rx_st_q)
        srx_pkg::RX_IDLE: begin
          hist_q <= {hist_q[1:0], smp_in};
          if (!ctrl_two_q[`SRX_C2_RE]) begin
            hist_q <= 3'b000;
          end else if (!smp_in) begin
            // falling edge: realign the sample index, latch the format
            smp_q   <= 5'h02;
            bidx_q  <= 4'h0;
            m_f_q   <= ctrl_one_q[`SRX_C1_M];
            pce_f_q <= ctrl_one_q[`SRX_C1_PCE];
            ps_f_q  <= ctrl_one_q[`SRX_C1_PS];
            rx_st_q <= srx_pkg::RX_START;
            if (hist_q != 3'b111) begin
              noise_acc_q <= 1'b1;
            end
          end
        end
        srx_pkg::RX_START: begin
          smp_q <= (smp_q == `SRX_SMP_LAST) ? 5'h01 : smp_q + 5'h01;
          if ((smp_q == `SRX_SMP_E3 || smp_q == `SRX_SMP_E5 || smp_q == `SRX_SMP_E7) && smp_in) begin
            noise_acc_q <= 1'b1;
          end
          if (smp_q == `SRX_SMP_MAJ_C) begin
            if (s89_q != 2'b00 || smp_in) begin
              noise_acc_q <= 1'b1;
            end
            if (maj) begin
              // false start: drop it, noise waits for the next good frame
              rx_st_q <= srx_pkg::RX_IDLE;
              hist_q  <= 3'b000;
            end
          end
          if (smp_q == `SRX_SMP_LAST) begin
            rx_st_q <= srx_pkg::RX_DATA;
          end
        end
        srx_pkg::RX_DATA: begin
          smp_q <= (smp_q == `SRX_SMP_LAST) ? 5'h01 : smp_q + 5'h01;
          if (smp_q == `SRX_SMP_MAJ_C) begin
            rsh_q[bidx_q] <= maj;
            if (unequal) begin
              noise_acc_q <= 1'b1;
            end
          end
          if (smp_q == `SRX_SMP_LAST) begin
            if (bidx_q == (m_f_q ? 4'h8 : 4'h7)) begin
              rx_st_q <= srx_pkg::RX_STOP;
            end else begin
              bidx_q <= bidx_q + 4'h1;
            end
          end
        end
        srx_pkg::RX_STOP: begin
          smp_q <= smp_q + 5'h01;
          if (smp_q == `SRX_SMP_MAJ_C) begin
            // early return to idle so a tight next start is not missed
            rx_st_q <= srx_pkg::RX_IDLE;
            hist_q  <= maj ? 3'b111 : 3'b000;
            if (accept) begin
              noise_acc_q <= 1'b0;
            end
          end
        end
        default: rx_st_q <= srx_pkg::RX_IDLE;
      endcase
    end
  end

  // ==========================================
  // idle line detector, armed by a finished frame
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idle_cnt_q <= 8'h00;
      idle_arm_q <= 1'b0;
    end else if (run) begin
      if (frame_end) begin
        idle_arm_q <= 1'b1;
      end else if (idle_hit) begin
        idle_arm_q <= 1'b0;
      end
      if (tick_q) begin
        if (rx_st_q != srx_pkg::RX_IDLE || !smp_in || idle_hit) begin
          idle_cnt_q <= 8'h00;
        end else begin
          idle_cnt_q <= idle_cnt_q + 8'h01;
        end
      end
    end
  end

  // ==========================================
  // register writes and clear sequence
  assign data_rd_clr = rd_i && (addr_i == `SRX_OFF_DATA) && seq_q;
  assign data_wr_clr = wr_i && (addr_i == `SRX_OFF_DATA) && seq_q;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_one_q <= `SRX_RST_CTRL_ONE;
      ctrl_two_q <= `SRX_RST_CTRL_TWO;
      baud_q     <= `SRX_RST_BAUD;
      tdr_q      <= 9'h000;
      tdr_full_q <= 1'b0;
      seq_q      <= 1'b0;
    end else if (run) begin
      if (rd_i && addr_i == `SRX_OFF_STATUS) begin
        seq_q <= 1'b1;
      end else if ((rd_i || wr_i) && addr_i == `SRX_OFF_DATA) begin
        seq_q <= 1'b0;
      end
      if (txif.take) begin
        tdr_full_q <= 1'b0;
      end
      if (frame_end && accept) begin
        ctrl_one_q[`SRX_C1_R8] <= rsh_q[8];
      end
      // hardware wakeup clears mute; a same-cycle write still wins
      if (frame_end && addr_wake) begin
        ctrl_two_q[`SRX_C2_MUTE] <= 1'b0;
      end
      if (idle_hit && rx_mute && !ctrl_one_q[`SRX_C1_WAKE]) begin
        ctrl_two_q[`SRX_C2_MUTE] <= 1'b0;
      end
      if (wr_i) begin
        case (addr_i)
          `SRX_OFF_CTRL_ONE: ctrl_one_q[6:0] <= wdata_i[6:0] & 7'h5f;
          `SRX_OFF_CTRL_TWO: ctrl_two_q      <= wdata_i & 8'hfe;
          `SRX_OFF_BAUD:     baud_q          <= wdata_i;
          `SRX_OFF_DATA: begin
            tdr_q      <= {ctrl_one_q[`SRX_C1_T8], wdata_i};
            tdr_full_q <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================
  // status flags: hardware set wins over software clear
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_empty_flag_q      <= 1'b1;
      tx_complete_flag_q   <= 1'b1;
      rx_data_ready_flag_q <= 1'b0;
      idle_flag_q          <= 1'b0;
      ovr_flag_q           <= 1'b0;
      noise_flag_q         <= 1'b0;
      frame_err_flag_q     <= 1'b0;
      parity_error_flag_q  <= 1'b0;
      rdr_q                <= 9'h000;
    end else if (run) begin
      if (data_wr_clr) begin
        tx_empty_flag_q    <= 1'b0;
        tx_complete_flag_q <= 1'b0;
      end
      if (txif.take) begin
        tx_empty_flag_q <= 1'b1;
      end
      if (txif.done) begin
        tx_complete_flag_q <= 1'b1;
      end
      if (data_rd_clr) begin
        rx_data_ready_flag_q <= 1'b0;
        idle_flag_q          <= 1'b0;
        ovr_flag_q           <= 1'b0;
        noise_flag_q         <= 1'b0;
        frame_err_flag_q     <= 1'b0;
        parity_error_flag_q  <= 1'b0;
      end
      if (frame_end && accept) begin
        if (rx_data_ready_flag_q && !data_rd_clr) begin
          ovr_flag_q <= 1'b1;
        end else begin
          rdr_q                <= rsh_q;
          rx_data_ready_flag_q <= 1'b1;
          noise_flag_q         <= noise_acc_q;
          frame_err_flag_q     <= stop_bad;
          parity_error_flag_q  <= par_err;
        end
      end
      if (idle_hit && !rx_mute) begin
        idle_flag_q <= 1'b1;
      end
    end
  end

  // ==========================================
  // read port: data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i && run) begin
      case (addr_i)
        `SRX_OFF_STATUS: rdata_o <= {tx_empty_flag_q, tx_complete_flag_q, rx_data_ready_flag_q, idle_flag_q,
                                     ovr_flag_q, noise_flag_q, frame_err_flag_q, parity_error_flag_q};
        `SRX_OFF_CTRL_ONE: rdata_o <= ctrl_one_q;
        `SRX_OFF_CTRL_TWO: rdata_o <= ctrl_two_q;
        `SRX_OFF_DATA:     rdata_o <= rdr_q[7:0];
        `SRX_OFF_BAUD:     rdata_o <= baud_q;
        default:           rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ==========================================
  // shared request; also the wait-mode wakeup
  always_comb begin
    irq_d = (tx_empty_flag_q && ctrl_two_q[`SRX_C2_TIE]) ||
            (tx_complete_flag_q && ctrl_two_q[`SRX_C2_TX_COMPLETE_IRQ_EN]) ||
            (!rx_mute && (rx_data_ready_flag_q || ovr_flag_q) && ctrl_two_q[`SRX_C2_RIE]) ||
            (!rx_mute && idle_flag_q && ctrl_two_q[`SRX_C2_IDLE_IRQ_EN]) ||
            (!rx_mute && parity_error_flag_q && ctrl_one_q[`SRX_C1_PIE]);
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_d && !cpu_int_mask_i && run;
    end
  end

endmodule

// ===== tb/srx_top_properties.sv
module srx_top_properties (
  input wire logic       ref_clk_i,
  input wire logic       arst_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic       halt_i,
  input wire logic       cpu_int_mask_i,
  input wire logic       rx_i,
  input wire logic [7:0] rdata_o,
  input wire logic       irq_o,
  input wire logic       tx_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // ==========================================
  // register port
  sequence s_wr_two;
    wr_i && !halt_i && addr_i == 3'h2;
  endsequence
  sequence s_rd_two;
    rd_i && !halt_i && addr_i == 3'h2;
  endsequence
  // mute bit left out: hardware may clear it between the two accesses
  property p_c2_back;
    s_wr_two ##1 s_rd_two |=> rdata_o[7:2] == $past(wdata_i[7:2], 2);
  endproperty
  property p_rd_quiet;
    !rd_i |=> rdata_o == 8'h00;
  endproperty
  property p_unmapped;
    rd_i && addr_i > 3'h4 |=> rdata_o == 8'h00;
  endproperty
  property p_halt_read;
    rd_i && halt_i |=> rdata_o == 8'h00;
  endproperty
  property p_c1_res;
    rd_i && !halt_i && addr_i == 3'h1 |=> !rdata_o[5];
  endproperty
  property p_c2_res;
    rd_i && !halt_i && addr_i == 3'h2 |=> !rdata_o[0];
  endproperty
  a_c2_back: assert property (p_c2_back) else $error("control two read back differs");
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data not zero outside a read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_halt_read: assert property (p_halt_read) else $error("read answered in halt");
  a_c1_res: assert property (p_c1_res) else $error("reserved control one bit set");
  a_c2_res: assert property (p_c2_res) else $error("reserved control two bit set");

  // ==========================================
  // interrupt and line
  property p_mask;
    cpu_int_mask_i |=> !irq_o;
  endproperty
  property p_halt_irq;
    halt_i |=> !irq_o;
  endproperty
  property p_irq_cause;
    $rose(irq_o) |-> !$past(cpu_int_mask_i) && !$past(halt_i);
  endproperty
  property p_start_len;
    $fell(tx_o) |=> !tx_o [*8];
  endproperty
  a_mask: assert property (p_mask) else $error("request while masked");
  a_halt_irq: assert property (p_halt_irq) else $error("request in halt");
  a_irq_cause: assert property (p_irq_cause) else $error("request rose without gate open");
  a_start_len: assert property (p_start_len) else $error("start bit too short");
endmodule

bind srx_top srx_top_properties srx_top_properties_i (
  .ref_clk_i     (ref_clk_i),
  .arst_n_i      (arst_n_i),
  .addr_i        (addr_i),
  .wdata_i       (wdata_i),
  .wr_i          (wr_i),
  .rd_i          (rd_i),
  .halt_i        (halt_i),
  .cpu_int_mask_i(cpu_int_mask_i),
  .rx_i          (rx_i),
  .rdata_o       (rdata_o),
  .irq_o         (irq_o),
  .tx_o          (tx_o)
);

// ===== tb/srx_node.sv
module srx_node (
  input  wire logic ref_clk_i,
  input  wire logic tx_i,
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial line_o = 1'b1;

  // ==========================================
  // frame out, sixteen clocks a bit at divisor 0
  // gbit inverts one clock mid-bit: -1 start bit, 99 none
  task automatic send(input logic [8:0] w, input int nb, input int gbit);
    logic [10:0] fr;
    fr = 11'h7ff;
    fr[0] = 1'b0;
    for (int i = 0; i < nb; i++) begin
      fr[i + 1] = w[i];
    end
    for (int i = 0; i < nb + 2; i++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge ref_clk_i);
        // clock 8 of a bit lands on sample 9 after the two-flop pin path
        line_o <= (i == gbit + 1 && c == 8) ? ~fr[i] : fr[i];
      end
    end
  endtask

  // ==========================================
  // frame in, sampled mid-bit
  task automatic recv(input int nb, output logic [8:0] w);
    int n;
    n = 0;
    w = 9'h000;
    while (tx_i !== 1'b0 && n < 4000) begin
      @(posedge ref_clk_i);
      n++;
    end
    repeat (8) @(posedge ref_clk_i);
    for (int i = 0; i < nb; i++) begin
      repeat (16) @(posedge ref_clk_i);
      w[i] = tx_i;
    end
  endtask
endmodule

// ===== tb/tb_srx_top.sv
module tb_srx_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic       ref_clk_i;
  logic       arst_n_i;
  logic [2:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic       halt_i;
  logic       cpu_int_mask_i;
  logic       rx_i;
  logic [7:0] rdata_o;
  logic       irq_o;
  logic       tx_o;
  logic [8:0] w;
  logic       p;
  int         n_fail;
  int         n_tests;
  int         gl[2] = '{-1, 3};

  srx_top srx_top_i (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .halt_i(halt_i), .cpu_int_mask_i(cpu_int_mask_i),
    .rx_i(rx_i), .rdata_o(rdata_o), .irq_o(irq_o), .tx_o(tx_o)
  );
  srx_node srx_node_i (.ref_clk_i(ref_clk_i), .tx_i(tx_o), .line_o(rx_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // ==========================================
  // bus tasks; a write strobe stands until the next bus call
  task automatic bus(input logic wv, input logic rv, input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i <= wv;
    rd_i <= rv;
    addr_i <= a;
    wdata_i <= d;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 3'h0, 8'h00);
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rdreg(input logic [2:0] a, input logic [7:0] e);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
    #1 chk(rdata_o, e);
  endtask
  task automatic clr();
    bus(1'b0, 1'b1, 3'h0, 8'h00);
    bus(1'b0, 1'b1, 3'h3, 8'h00);
    idle(1);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  function automatic logic par(input logic [7:0] d, input logic odd, input logic m);
    return (m ? ^d : ^d[6:0]) ^ odd;
  endfunction

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    conclude();
  end

  // ==========================================
  // main sequence
  initial begin
    {arst_n_i, addr_i, wdata_i, wr_i, rd_i, halt_i, cpu_int_mask_i} = '0;
    n_fail = 0;
    n_tests = 0;
    repeat (10) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    rdreg(3'h0, 8'hc0);
    rdreg(3'h1, 8'h00);
    rdreg(3'h4, 8'h00);
    wreg(3'h5, 8'hff);
    rdreg(3'h5, 8'h00);
    wreg(3'h4, 8'h00);
    wreg(3'h2, 8'h24);
    rdreg(3'h2, 8'h24);
    $display("test registers done");
    node_send(9'h0a5, 8, 99);
    chk({7'h00, irq_o}, 8'h01);
    @(posedge ref_clk_i);
    cpu_int_mask_i <= 1'b1;
    idle(2);
    #1 chk({7'h00, irq_o}, 8'h00);
    @(posedge ref_clk_i);
    cpu_int_mask_i <= 1'b0;
    node_send(9'h03c, 8, 99);
    rdreg(3'h0, 8'he8);
    rdreg(3'h3, 8'ha5);
    rdreg(3'h0, 8'hc0);
    $display("test receive and overrun done");
    wreg(3'h2, 8'h04);
    for (int m = 0; m < 2; m++) begin
      for (int ps = 0; ps < 4; ps++) begin
        wreg(3'h1, {3'h0, m[0], 1'b0, 1'b1, ps[0], 1'b1});
        p = par(8'h35, ps[0], m[0]) ^ ps[1];
        w = m[0] ? {p, 8'h35} : {1'b0, p, 7'h35};
        node_send(w, m[0] ? 9 : 8, 99);
        chk({7'h00, irq_o}, {7'h00, ps[1]});
        rdreg(3'h0, {7'h70, ps[1]});
        clr();
      end
    end
    $display("test parity done");
    wreg(3'h1, 8'h00);
    for (int k = 0; k < 2; k++) begin
      node_send(9'h05a, 8, gl[k]);
      rdreg(3'h0, 8'he4);
      rdreg(3'h3, 8'h5a);
    end
    $display("test noise done");
    wreg(3'h1, 8'h08);
    wreg(3'h2, 8'h26);
    node_send(9'h012, 8, 99);
    rdreg(3'h0, 8'hc0);
    chk({7'h00, irq_o}, 8'h00);
    node_send(9'h092, 8, 99);
    rdreg(3'h2, 8'h24);
    rdreg(3'h0, 8'he0);
    rdreg(3'h3, 8'h92);
    wreg(3'h1, 8'h0c);
    wreg(3'h2, 8'h26);
    node_send(9'h081, 8, 99);
    rdreg(3'h0, 8'hc0);
    node_send(9'h041, 8, 99);
    rdreg(3'h2, 8'h24);
    rdreg(3'h0, 8'he0);
    rdreg(3'h3, 8'h41);
    wreg(3'h1, 8'h00);
    node_send(9'h055, 8, 99);
    wreg(3'h2, 8'h36);
    idle(400);
    rdreg(3'h2, 8'h34);
    rdreg(3'h0, 8'he0);
    rdreg(3'h3, 8'h55);
    $display("test mute done");
    @(posedge ref_clk_i);
    halt_i <= 1'b1;
    wreg(3'h2, 8'h00);
    rdreg(3'h0, 8'h00);
    @(posedge ref_clk_i);
    halt_i <= 1'b0;
    rdreg(3'h2, 8'h34);
    $display("test halt done");
    wreg(3'h2, 8'h08);
    for (int ps = 0; ps < 2; ps++) begin
      wreg(3'h1, {5'h00, 1'b1, ps[0], 1'b0});
      fork
        srx_node_i.recv(8, w);
        begin
          wreg(3'h3, 8'h83);
          idle(1);
        end
      join
      chk(w[7:0], ps[0] ? 8'h83 : 8'h03);
      idle(200);
    end
    wreg(3'h2, 8'h88);
    idle(3);
    #1 chk({7'h00, irq_o}, 8'h01);
    $display("test transmit done");
    conclude();
  end

  // frame in from the node, then two clocks for the flags to land
  task automatic node_send(input logic [8:0] wv, input int nb, input int gbit);
    idle(1);
    srx_node_i.send(wv, nb, gbit);
    idle(2);
    #1;
  endtask
endmodule
